// ### hdl/serial_eeprom_write_target.sv
// serial two-wire memory target: framing, address decode, page write, polling
// assumes an outside controller makes the serial clock; pull-up on the data line
//
// Contract
// - sample on rising edge, drive after falling
// - data line driven low or released only
// - data fall with clock high is start
// - data rise with clock high is stop
// - stop after write data launches timed write
// - eight bits, msb first, ninth clock acknowledges
// - acknowledge every received write word
// - read byte acked zero sends next address
// - no ack then stop ends read
// - no ack, no stop: stay released
// - address word: type, select, read/write
// - mismatch gives no acknowledge, back to standby
// - match acknowledges, then read or write
// - small variant compares upper select only
// - large variant compares no select bits
// - flag zero writes, flag one reads
// - byte write, stop starts cycle, ignore bus
// - extra bytes buffer up to thirty-two
// - page offset wraps within same page
// - busy: write address word not acknowledged
// - protect high blocks all array writes
// - reads work regardless of protect level
// - write cycle ends within 10/15 ms

`timescale 1ns/1ns
module serial_eeprom_write_target
    import eeprom_target_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,        // 1: 2048 bytes, 0: 1024 bytes
    parameter int WC_CYC_HI_P   = WC_CYC_HI,   // write cycle count, high supply
    parameter int WC_CYC_LO_P   = WC_CYC_LO    // write cycle count, low supply
)
(
    // system clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // serial bus
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe_n,
    // straps and control pins
    input  wire logic i_select_strap_two,
    input  wire logic i_write_protect,
    input  wire logic i_low_supply,
    // status
    output logic      o_busy
);


    // pin synchronisers for the static control pins

    localparam int PIN_N = 3;

    logic [PIN_N-1:0] pin_meta;                 // first stage, read only by pin_sync
    logic [PIN_N-1:0] pin_sync;                 // second stage
    wire  [PIN_N-1:0] pin_raw = {i_low_supply, i_write_protect, i_select_strap_two};


    generate
        for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
            // two flops per pin before any logic looks at it
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pin_meta[g] <= 1'b0;
                    pin_sync[g] <= 1'b0;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    wire strap_two_s = pin_sync[0];
    wire protect_s   = pin_sync[1];
    wire low_sup_s   = pin_sync[2];


    // front end: sampling, start/stop detection, pin drive

    logic start_ev;          // one-cycle start pulse
    logic stop_ev;           // one-cycle stop pulse
    logic bit_ev;            // one-cycle pulse per received clock
    logic bit_val;           // data bit of that clock
    logic drive_low;         // request to pull the line low at next fall

    serial_link_front u_front (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_scl       (i_scl),
        .i_sda       (i_sda),
        .i_drive_low (drive_low),
        .o_start     (start_ev),
        .o_stop      (stop_ev),
        .o_bit_ev    (bit_ev),
        .o_bit_val   (bit_val),
        .o_sda       (o_sda),
        .o_sda_oe_n  (o_sda_oe_n)
    );


    // protocol state

    link_state_e          state;        // protocol phase
    logic [3:0]           bitcnt;       // clock index inside a byte, 8 = ninth
    logic [7:0]           shreg;        // incoming bits, msb first
    logic [7:0]           tx;           // outgoing read byte
    logic                 rw;           // latched read/write flag
    logic                 wp_lat;       // protect level held for the transaction
    logic [ADDR_W-1:0]    addr_cnt;     // current address counter

    // page buffer and its fill marks
    logic [7:0]           page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld;

    // write cycle engine
    logic [WC_CNT_W-1:0]  timer;        // cycles left in the internal write
    logic                 committing;   // copying the page into the array
    logic [PAGE_W-1:0]    commit_idx;   // entry being copied
    logic [PAGE_NUM_W-1:0] page_base;   // page being written

    // the array itself; the small variant never reaches the upper half
    logic [7:0]           mem [MEM_DEPTH];


    // decode

    wire [7:0] rx_byte   = {shreg[6:0], bit_val};
    wire       type_ok   = (rx_byte[TYPE_MSB:TYPE_LSB] == TYPE_CODE);
    // small variant compares only the upper select bit with its strap
    wire       sel_ok    = LARGE_VARIANT ? 1'b1
                                         : (rx_byte[SEL_TOP] == strap_two_s);
    wire       addr_hit  = type_ok & sel_ok;

    // select bits that become memory address bits ten, nine and eight
    wire [2:0] hi_bits   = LARGE_VARIANT ? rx_byte[SEL_TOP:SEL_LOW]
                                         : {1'b0, rx_byte[SEL_MID:SEL_LOW]};
    wire       last_bit  = (bitcnt == BIT_LAST);
    wire       ack_clk   = (bitcnt == BIT_ACK);

    // sequential read steps over the whole array and rolls to zero
    wire [ADDR_W-1:0] rd_sum  = addr_cnt + ADDR_ONE;
    wire [ADDR_W-1:0] rd_next = LARGE_VARIANT ? rd_sum : {1'b0, rd_sum[ADDR_W-2:0]};

    // page writes step only the offset bits
    wire [PAGE_W-1:0] pg_off  = addr_cnt[PAGE_W-1:0] + PAGE_ONE;
    wire [ADDR_W-1:0] pg_next = {addr_cnt[ADDR_W-1:PAGE_W], pg_off};
    wire [7:0]        rd_byte = mem[addr_cnt];

    // byte accepted into the page buffer; a protected write is still
    // acknowledged, but the byte never enters the buffer
    wire accept_byte = bit_ev & (state == ST_WR_DATA) & last_bit & ~wp_lat;
    wire launch      = stop_ev & (state == ST_WR_DATA) & (|page_vld) & ~wp_lat;
    wire wc_done     = o_busy & (timer == WC_CNT_W'(1));

    // cycle count for the supply range in use
    wire [WC_CNT_W-1:0] wc_load = low_sup_s ? WC_CNT_W'(WC_CYC_LO_P)
                                            : WC_CNT_W'(WC_CYC_HI_P);


    // protocol engine; start has priority over stop, stop over bits

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= ST_IDLE;
            bitcnt    <= BIT_FIRST;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            rw        <= RW_WRITE;
            wp_lat    <= 1'b0;
            addr_cnt  <= '0;
            drive_low <= 1'b0;
        end else if (start_ev) begin
            // any start, even mid-byte, restarts address reception
            state     <= ST_DEV_ADDR;
            bitcnt    <= BIT_FIRST;
            drive_low <= 1'b0;
            wp_lat    <= protect_s;

        end else if (stop_ev) begin
            // stop ends reading and writing alike; launch is picked up below
            state     <= ST_IDLE;
            drive_low <= 1'b0;
        end else if (bit_ev) begin
            unique case (state)
                ST_DEV_ADDR: begin
                    shreg <= rx_byte;
                    if (last_bit) begin
                        // busy or mismatch: leave the line released, stand by
                        if (addr_hit && !o_busy) begin
                            drive_low <= 1'b1;
                            rw        <= rx_byte[RW_BIT];
                            bitcnt    <= BIT_ACK;
                            if (rx_byte[RW_BIT] == RW_WRITE) begin
                                addr_cnt <= {hi_bits, addr_cnt[LOW_ADDR_W-1:0]};
                            end
                        end else begin
                            state     <= ST_IGNORE;
                            drive_low <= 1'b0;
                        end
                    end else if (ack_clk) begin
                        if (rw == RW_READ) begin
                            // first read bit goes out at the next fall
                            state     <= ST_RD_DATA;
                            tx        <= rd_byte;
                            drive_low <= ~rd_byte[7];
                        end else begin
                            state     <= ST_MEM_ADDR;
                            drive_low <= 1'b0;
                        end
                        bitcnt <= BIT_FIRST;
                    end else begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                end

                ST_MEM_ADDR: begin
                    shreg <= rx_byte;
                    if (last_bit) begin
                        addr_cnt  <= {addr_cnt[ADDR_W-1:LOW_ADDR_W], rx_byte};
                        drive_low <= 1'b1;
                        bitcnt    <= BIT_ACK;
                    end else if (ack_clk) begin
                        state     <= ST_WR_DATA;
                        drive_low <= 1'b0;
                        bitcnt    <= BIT_FIRST;
                    end else begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                end

                ST_WR_DATA: begin
                    shreg <= rx_byte;
                    if (last_bit) begin
                        // each extra byte steps the offset, wrapping in page
                        addr_cnt  <= pg_next;
                        drive_low <= 1'b1;
                        bitcnt    <= BIT_ACK;
                    end else if (ack_clk) begin
                        drive_low <= 1'b0;
                        bitcnt    <= BIT_FIRST;
                    end else begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                end

                ST_RD_DATA: begin
                    if (last_bit) begin
                        // release for the controller's acknowledge
                        drive_low <= 1'b0;
                        addr_cnt  <= rd_next;
                        bitcnt    <= BIT_ACK;
                    end else if (ack_clk) begin
                        if (bit_val == ACK_ZERO) begin
                            tx        <= rd_byte;
                            drive_low <= ~rd_byte[7];
                            bitcnt    <= BIT_FIRST;
                        end else begin
                            // no acknowledge: hold released until stop or start
                            state     <= ST_IGNORE;
                            drive_low <= 1'b0;
                        end
                    end else begin
                        tx        <= {tx[6:0], 1'b0};
                        drive_low <= ~tx[6];
                        bitcnt    <= bitcnt + 4'h1;
                    end
                end

                ST_IDLE, ST_IGNORE: begin
                    // clocks without a start are not ours to answer
                    drive_low <= 1'b0;
                end
            endcase
        end
    end


    // page buffer fill marks; a new mark wins over a same-cycle clear

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_vld <= '0;
        end else if (accept_byte) begin
            page_vld[addr_cnt[PAGE_W-1:0]] <= 1'b1;
        end else if (wc_done || (start_ev && !o_busy)) begin
            // a start without stop discards what was gathered so far
            page_vld <= '0;
        end
    end

    // page data; a wrapped offset simply overwrites the earlier byte
    always_ff @(posedge i_clk) begin
        if (accept_byte) begin
            page_buf[addr_cnt[PAGE_W-1:0]] <= rx_byte;
        end
    end


    // internal write cycle: busy for the whole duration, bus ignored

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy     <= 1'b0;
            timer      <= '0;
            committing <= 1'b0;
            commit_idx <= '0;
            page_base  <= '0;
        end else if (launch && !o_busy) begin
            o_busy     <= 1'b1;
            timer      <= wc_load;
            committing <= 1'b1;
            commit_idx <= '0;
            page_base  <= addr_cnt[ADDR_W-1:PAGE_W];
        end else if (o_busy) begin
            if (wc_done) begin
                o_busy <= 1'b0;
            end
            timer <= timer - WC_CNT_W'(1);
            if (committing) begin
                commit_idx <= commit_idx + PAGE_ONE;
                committing <= (commit_idx != PAGE_LAST);
            end
        end
    end

    // array update, one page entry per clock while the cycle runs;
    // copying early is safe because the bus is shut out until it ends
    always_ff @(posedge i_clk) begin
        if (committing && page_vld[commit_idx]) begin
            mem[{page_base, commit_idx}] <= page_buf[commit_idx];
        end
    end

endmodule

// ### hdl/eeprom_target_pkg.sv
// constants, field layout and states shared by the serial memory target
// assumes a 10 MHz system clock and a serial clock made by an outside controller
package eeprom_target_pkg;

    // system clock
    localparam int CLK_PERIOD_NS   = 100;            // 10 MHz system clock

    // internal write duration, per supply range
    localparam int WC_TIME_HI_MS   = 10;             // supply 2.7 V and above
    localparam int WC_TIME_LO_MS   = 15;             // supply below 2.7 V
    localparam int NS_PER_MS       = 1000000;
    // longest times round down to whole cycles
    localparam int WC_CYC_HI       = WC_TIME_HI_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int WC_CYC_LO       = WC_TIME_LO_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int WC_CNT_W        = 18;             // holds the longer count

    // address word layout
    localparam logic [3:0] TYPE_CODE = 4'h5;         // arbitrary value, stands in for the fixed type code
    localparam int TYPE_MSB        = 7;
    localparam int TYPE_LSB        = 4;
    localparam int SEL_TOP         = 3;              // select field upper bit
    localparam int SEL_MID         = 2;
    localparam int SEL_LOW         = 1;
    localparam int RW_BIT          = 0;
    localparam logic RW_WRITE      = 1'b0;
    localparam logic RW_READ       = 1'b1;

    // byte framing
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST  = 4'h7;         // eighth data bit
    localparam logic [3:0] BIT_ACK   = 4'h8;         // ninth clock
    localparam logic       ACK_ZERO  = 1'b0;

    // memory geometry
    localparam int ADDR_W          = 11;             // up to 2048 bytes
    localparam int MEM_DEPTH       = 2048;
    localparam int LOW_ADDR_W      = 8;              // memory address byte
    localparam int PAGE_W          = 5;              // page offset bits
    localparam int PAGE_BYTES      = 32;
    localparam int PAGE_NUM_W      = ADDR_W - PAGE_W;
    localparam logic [PAGE_W-1:0] PAGE_ONE  = 5'h01;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1F;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 11'h001;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV_ADDR,
        ST_MEM_ADDR,
        ST_WR_DATA,
        ST_RD_DATA,
        ST_IGNORE
    } link_state_e;

endpackage

// ### hdl/serial_link_front.sv
// pin front end: serial clock domain sampler plus system clock synchronisers
// assumes the serial clock may stop between frames; data line is open drain
`timescale 1ns/1ns
module serial_link_front
    import eeprom_target_pkg::*;
(
    // clocks and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // bus pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    // drive request from the protocol engine
    input  wire logic i_drive_low,
    // events toward the protocol engine
    output logic      o_start,
    output logic      o_stop,
    output logic      o_bit_ev,
    output logic      o_bit_val,
    // data pin drive
    output logic      o_sda,
    output logic      o_sda_oe_n
);

    logic smp;       // data bit taken at the serial rising edge
    logic tgl;       // flips on every serial rising edge
    logic scl_m, scl_s, scl_p;   // serial clock synchroniser and history
    logic sda_m, sda_s, sda_p;   // data line synchroniser and history
    logic tgl_m, tgl_s, tgl_p;   // bit toggle synchroniser and history

    wire scl_fall = scl_p & ~scl_s;
    wire start_c  = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_c   = scl_s & scl_p & ~sda_p & sda_s;

    // serial domain: sample on the rising edge only
    always_ff @(posedge i_scl or negedge i_rst_n) begin
        if (!i_rst_n) begin
            smp <= 1'b0;
            tgl <= 1'b0;
        end else begin
            smp <= i_sda;
            tgl <= ~tgl;
        end
    end

    // system domain synchronisers, the first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            {tgl_m, tgl_s, tgl_p} <= 3'h0;
        end else begin
            {scl_m, scl_s, scl_p} <= {i_scl, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {i_sda, sda_m, sda_s};
            {tgl_m, tgl_s, tgl_p} <= {tgl, tgl_m, tgl_s};
        end
    end

    // event pulses; smp is stable for a whole clock half by the time the
    // toggle lands here, so it is read as held data of the toggle handshake
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_start   <= 1'b0;
            o_stop    <= 1'b0;
            o_bit_ev  <= 1'b0;
            o_bit_val <= 1'b0;
        end else begin
            o_start   <= start_c;
            o_stop    <= stop_c;
            o_bit_ev  <= tgl_s ^ tgl_p;
            o_bit_val <= smp;
        end
    end

    // pin drive changes only after a serial falling edge, and only ever low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda      <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else begin
            o_sda <= 1'b0;
            if (scl_fall) begin
                o_sda_oe_n <= ~i_drive_low;
            end
        end
    end

endmodule

// ### testbench/eeprom_target_props.sv
// concurrent checks on the memory target's top ports
// assumes scl phases of 8 or more system clocks
`timescale 1ns/1ns
module eeprom_target_props
    import eeprom_target_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int WC_CYC_LO_P   = 600
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire logic i_select_strap_two,
    input wire logic i_write_protect,
    input wire logic o_busy
);
    localparam int WC_MAX = WC_CYC_LO_P + 2; // two cycles of slack
    logic [1:0] scl_q;                       // scl history, bit 0 newest
    logic [1:0] sda_q;                       // sda history
    logic [3:0] bits;                        // clock index in the byte, 8 = ninth
    logic [7:0] shreg;                       // received bits
    logic       first;                       // still in the address word
    logic [3:0] since_stop;                  // saturating age of last stop
    wire rise_scl  = scl_q == 2'b01;
    wire start_ev  = scl_q[0] && sda_q == 2'b10;
    wire stop_ev   = scl_q[0] && sda_q == 2'b01;
    wire nine_rise = rise_scl && bits == BIT_ACK && first;
    // strap only matters in the small variant
    wire addr_ok   = shreg[7:4] == TYPE_CODE && (LARGE_VARIANT || shreg[3] == i_select_strap_two);
    // bit framing seen from the wire
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {scl_q, sda_q} <= 4'hF;
            bits <= 4'h0;
            first <= 1'b0;
            shreg <= 8'h00;
            since_stop <= 4'hF;
        end else begin
            scl_q <= {scl_q[0], i_scl};
            sda_q <= {sda_q[0], i_sda};
            since_stop <= stop_ev ? 4'h0 : since_stop + {3'h0, ~&since_stop};
            if (start_ev) begin
                bits <= 4'h0;
                first <= 1'b1;
            end else if (rise_scl) begin
                bits <= (bits == BIT_ACK) ? 4'h0 : bits + 4'h1;
                first <= first && bits != BIT_ACK;
                if (bits != BIT_ACK) shreg <= {shreg[6:0], sda_q[0]};
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_drive_low_only: assert property (o_sda == 1'b0) else $error("data drive not low");
    a_change_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl) else $error("drive moved, scl high");
    a_busy_released: assert property (o_busy |-> o_sda_oe_n) else $error("driving while busy");
    a_busy_cause: assert property ($rose(o_busy) |-> since_stop < 4'h8) else $error("busy without stop");
    a_busy_hold: assert property ($rose(o_busy) |=> o_busy [*8]) else $error("busy too short");
    a_busy_bound: assert property ($rose(o_busy) |-> ##[1:WC_MAX] !o_busy) else $error("busy too long");
    a_protect_no_write: assert property ($rose(o_busy) |-> !i_write_protect) else $error("protected write ran");
    a_addr_mismatch: assert property (nine_rise && !addr_ok |-> o_sda_oe_n) else $error("foreign word acked");
    a_addr_ack: assert property (nine_rise && addr_ok && !$past(o_busy, 12) |-> !o_sda_oe_n)
        else $error("own word not acked");
    c_busy: cover property ($rose(o_busy));
    c_ack: cover property (nine_rise && !o_sda_oe_n);
    c_nack: cover property (nine_rise && o_sda_oe_n);
endmodule

bind serial_eeprom_write_target eeprom_target_props #(.LARGE_VARIANT(LARGE_VARIANT), .WC_CYC_LO_P(WC_CYC_LO_P))
    props (.i_clk, .i_rst_n, .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .i_select_strap_two, .i_write_protect, .o_busy);

// ### testbench/bus_host_model.sv
// bus controller model: scl within frames, sda pulled low or released
// assumes a pull-up on sda; scl idles high
`timescale 1ns/1ns
module bus_host_model (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial {o_scl, o_sda_low} = 2'b10;
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // one scl period, 12 clocks low then 12 high; data moves only while low
    task automatic clk_bit(input logic b, output logic r);
        wait_clk(4);
        o_sda_low <= !b;
        wait_clk(8);
        o_scl <= 1'b1;
        wait_clk(6);
        r = i_sda;
        wait_clk(6);
        o_scl <= 1'b0;
    endtask
    // s high: start, sda falls under high scl; s low: stop, scl stays high
    task automatic cond(input logic s);
        wait_clk(4);
        o_sda_low <= !s;
        wait_clk(8);
        o_scl <= 1'b1;
        wait_clk(12);
        o_sda_low <= s;
        wait_clk(12);
        if (s) o_scl <= 1'b0;
    endtask
    // msb first, line released on the ninth clock for the answer
    task automatic send(input logic [7:0] d, output logic [7:0] ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = {7'h00, r};
    endtask
    task automatic recv(input logic ack_b, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(ack_b, r);
    endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the serial memory target
// assumes the host model drives the bus; pull-up on the wire
`timescale 1ns/1ns
module tb_top
    import eeprom_target_pkg::*;
;
    localparam logic [2:0] SEL = 3'h5;   // memory bits 10..8
    logic       i_clk = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_write_protect = 1'b0;
    logic       i_low_supply = 1'b1;
    logic       scl;
    logic       host_low;
    logic       o_sda_oe_n;
    logic       o_busy;
    logic [7:0] ack;
    logic [7:0] d;
    int         error_cnt = 0;
    int         checks = 0;
    int         cyc = 0;
    wire sda = !host_low && o_sda_oe_n;   // open drain, pull-up
    always #50 i_clk = ~i_clk;
    serial_eeprom_write_target #(.LARGE_VARIANT(1'b1), .WC_CYC_HI_P(400), .WC_CYC_LO_P(600)) DUT (
        .i_clk, .i_rst_n, .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe_n,
        .i_select_strap_two(1'b0), .i_write_protect, .i_low_supply, .o_busy);
    bus_host_model host (.i_clk, .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hang is cut short here
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] aw(input logic rw);
        return {TYPE_CODE, SEL, rw};
    endfunction
    task automatic set_addr(input logic [7:0] a);
        host.cond(1'b1);
        host.send(aw(RW_WRITE), ack); chk("addr ack", 8'h00, ack);
        host.send(a, ack); chk("mem addr ack", 8'h00, ack);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        set_addr(a);
        host.cond(1'b1);
        host.send(aw(RW_READ), ack); chk("read addr ack", 8'h00, ack);
        host.recv(1'b1, d); chk("read data", exp, d);
        host.cond(1'b0);
    endtask
    task automatic t_page();
        set_addr(8'h3E);
        for (int i = 0; i < 33; i++) begin
            host.send(8'hA0 + i[7:0], ack); chk("data ack", 8'h00, ack);
        end
        host.cond(1'b0);
        chk("busy after stop", 8'h01, {7'h00, o_busy});
        host.cond(1'b1);
        host.send(aw(RW_WRITE), ack); chk("poll while busy", 8'h01, ack);
        host.cond(1'b0);
        for (int i = 0; i < 700 && o_busy !== 1'b0; i++) @(posedge i_clk);
        chk("busy ended", 8'h00, {7'h00, o_busy});
        host.cond(1'b1);
        host.send(aw(RW_WRITE), ack); chk("poll after write", 8'h00, ack);
        host.cond(1'b0);
        rd(8'h3E, 8'hC0);
        rd(8'h20, 8'hA2);
        $display("t_page done");
    endtask
    task automatic t_read_seq();
        set_addr(8'h3E);
        host.cond(1'b1);
        host.send(aw(RW_READ), ack);
        host.recv(1'b0, d); chk("seq byte 0", 8'hC0, d);
        host.recv(1'b1, d); chk("seq byte 1", 8'hA1, d);
        host.recv(1'b1, d); chk("released after nack", 8'hFF, d);
        host.cond(1'b0);
        $display("t_read_seq done");
    endtask
    task automatic t_restart();
        host.cond(1'b1);
        host.send({~TYPE_CODE, SEL, RW_WRITE}, ack); chk("wrong type", 8'h01, ack);
        host.cond(1'b1);
        host.send(aw(RW_WRITE), ack); chk("restart ack", 8'h00, ack);
        repeat (3) host.clk_bit(1'b0, d[0]);
        rd(8'h3F, 8'hA1);
        $display("t_restart done");
    endtask
    task automatic t_protect();
        i_write_protect <= 1'b1;
        set_addr(8'h3F);
        host.send(8'h5A, ack); chk("protected data ack", 8'h00, ack);
        host.cond(1'b0);
        chk("no busy when protected", 8'h00, {7'h00, o_busy});
        rd(8'h3F, 8'hA1);
        i_write_protect <= 1'b0;
        $display("t_protect done");
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_page();
        t_read_seq();
        t_restart();
        t_protect();
        conclude();
    end
endmodule
